// ==== tcc_timer.v ====
// Timer/counter with auto capture, staged compare, external trigger and event counting.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_defines.vh"

// How it works
// - With auto capture on, software can sample the live count, running or stopped.
// - Reading capture low byte is the capture instant; high byte loads simultaneously.
// - Stopped: capture low reads zero; that read clears the high byte.
// - Auto capture set before start works from the first cycle after start.
// - A write stopping the timer leaves the auto capture bit unchanged.
// - Compare low byte goes to a holding latch; high write commits both.
// - Double buffer bit: 0 disables, 1 enables compare double buffering.
// - Buffered, running: the value waits, moves to active at next match.
// - With double buffering, compare reads return the last written value.
// - Commit while stopped updates active compare and buffer at once.
// - Unbuffered, running: commit acts at once; lower value waits for wrap.
// - Mode 100 is external trigger; edge select 0 rising, 1 falling.
// - While running, mode register and overflow enable writes are ignored.
// - External trigger: count after trigger; match interrupts, clears, keeps counting.
// - Stop bit 1: opposite edge stops and clears; next trigger restarts.
// - Stop bit 0: both edges ignored from trigger until next match.
// - Writing run bit 0 stops the counter and clears it.
// - Mode 010 counts selected input edges; edge select 0 rising, 1 falling.
// - Event mode: match interrupts, clears the count, counting continues.
// - Sixteen bit up counter; compare and capture split into two bytes.
module tcc_timer (
   input wire mclk,
   input wire reset_n,
   input wire clk_en,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [4:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire timer_input_pin,
   output reg timer_interrupt_request
);

   localparam ST_WAIT = 2'b01;
   localparam ST_COUNT = 2'b10;

   reg run_bit_ff;
   reg auto_capture_bit_ff;
   reg double_buffer_bit_ff;
   reg overflow_irq_enable_ff;
   reg [2:0] mode_select_field_ff;
   reg edge_select_bit_ff;
   reg stop_on_opposite_edge_bit_ff;
   reg [1:0] source_clock_select_ff;
   reg [7:0] cmp_hold_ff;
   reg [15:0] cmp_active_ff;
   reg [15:0] cmp_buf_ff;
   reg [7:0] capture_low_byte_ff;
   reg [7:0] capture_high_byte_ff;
   reg [15:0] count_ff;
   reg [15:0] nxt_count;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg ignore_ff;
   reg nxt_ignore;
   reg match;
   reg [`TCC_PRESC_W-1:0] presc_ff;
   reg [`TCC_PRESC_W-1:0] presc_mask;
   reg pin_meta_ff;
   reg pin_sync_ff;
   reg pin_prev_ff;
   reg [7:0] rd_mux;

   wire bus_req;
   wire wr_en;
   wire rd_en;
   wire [2:0] reg_idx;
   wire [7:0] wdat;
   wire [15:0] count_inc;
   wire rise_edge;
   wire fall_edge;
   wire trig_edge;
   wire opp_edge;
   wire tick;
   wire cap_lo_read;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
   assign rd_en = bus_req & ~wb_we_i;
   assign reg_idx = wb_adr_i[4:2];
   assign wdat = wb_dat_i[7:0];
   assign count_inc = count_ff + 16'h0001;
   assign cap_lo_read = rd_en & (reg_idx == `TCC_IDX_CAP_LO) & auto_capture_bit_ff;

   // Pin synchroniser and edge detector.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_ff <= 1'b0;
         pin_sync_ff <= 1'b0;
         pin_prev_ff <= 1'b0;
      end else if (clk_en) begin
         pin_meta_ff <= timer_input_pin;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   assign rise_edge = pin_sync_ff & ~pin_prev_ff;
   assign fall_edge = ~pin_sync_ff & pin_prev_ff;
   assign trig_edge = edge_select_bit_ff ? fall_edge : rise_edge;
   assign opp_edge = edge_select_bit_ff ? rise_edge : fall_edge;

   // Source clock prescaler.
   always @* begin
      case (source_clock_select_ff)
         2'b00: presc_mask = `TCC_PRESC_MASK0;
         2'b01: presc_mask = `TCC_PRESC_MASK1;
         2'b10: presc_mask = `TCC_PRESC_MASK2;
         default: presc_mask = `TCC_PRESC_MASK3;
      endcase
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         presc_ff <= {`TCC_PRESC_W{1'b0}};
      end else if (clk_en) begin
         presc_ff <= presc_ff + {{(`TCC_PRESC_W-1){1'b0}}, 1'b1};
      end
   end

   assign tick = ((presc_ff & presc_mask) == presc_mask);

   // Counter and trigger sequencing.
   always @* begin
      nxt_count = count_ff;
      nxt_state = state_ff;
      nxt_ignore = ignore_ff;
      match = 1'b0;
      if (!run_bit_ff) begin
         nxt_count = `TCC_COUNT_RST;
         nxt_state = ST_WAIT;
         nxt_ignore = 1'b0;
      end else if (mode_select_field_ff == `TCC_MODE_EVENT) begin
         if (trig_edge) begin
            if (count_inc == cmp_active_ff) begin
               nxt_count = `TCC_COUNT_RST;
               match = 1'b1;
            end else begin
               nxt_count = count_inc;
            end
         end
      end else if (mode_select_field_ff == `TCC_MODE_EXT_TRIG) begin
         case (state_ff)
            ST_WAIT: begin
               if (trig_edge) begin
                  nxt_state = ST_COUNT;
                  nxt_count = `TCC_COUNT_RST;
                  nxt_ignore = ~stop_on_opposite_edge_bit_ff;
               end
            end
            ST_COUNT: begin
               if (stop_on_opposite_edge_bit_ff && opp_edge) begin
                  nxt_state = ST_WAIT;
                  nxt_count = `TCC_COUNT_RST;
               end else if (trig_edge && !stop_on_opposite_edge_bit_ff && !ignore_ff) begin
                  nxt_count = `TCC_COUNT_RST;
                  nxt_ignore = 1'b1;
               end else if (tick) begin
                  if (count_inc == cmp_active_ff) begin
                     nxt_count = `TCC_COUNT_RST;
                     match = 1'b1;
                     nxt_ignore = 1'b0;
                  end else begin
                     nxt_count = count_inc;
                  end
               end
            end
            default: begin
               nxt_state = ST_WAIT;
               nxt_count = `TCC_COUNT_RST;
            end
         endcase
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_ff <= `TCC_COUNT_RST;
         state_ff <= ST_WAIT;
         ignore_ff <= 1'b0;
         timer_interrupt_request <= 1'b0;
      end else if (clk_en) begin
         count_ff <= nxt_count;
         state_ff <= nxt_state;
         ignore_ff <= nxt_ignore;
         timer_interrupt_request <= match;
      end
   end

   // Control and mode registers.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         run_bit_ff <= 1'b0;
         auto_capture_bit_ff <= 1'b0;
         double_buffer_bit_ff <= 1'b0;
         overflow_irq_enable_ff <= 1'b0;
         mode_select_field_ff <= 3'h0;
         edge_select_bit_ff <= 1'b0;
         stop_on_opposite_edge_bit_ff <= 1'b0;
         source_clock_select_ff <= 2'h0;
      end else if (clk_en) begin
         if (wr_en && reg_idx == `TCC_IDX_CTRL) begin
            run_bit_ff <= wdat[`TCC_CTRL_RUN];
            double_buffer_bit_ff <= wdat[`TCC_CTRL_DBUF];
            if (!(run_bit_ff && !wdat[`TCC_CTRL_RUN])) begin
               auto_capture_bit_ff <= wdat[`TCC_CTRL_ACAP];
            end
            if (!run_bit_ff) begin
               overflow_irq_enable_ff <= wdat[`TCC_CTRL_OVFE];
            end
         end
         if (wr_en && reg_idx == `TCC_IDX_MODE && !run_bit_ff) begin
            mode_select_field_ff <= wdat[`TCC_MODE_SEL_MSB:`TCC_MODE_SEL_LSB];
            edge_select_bit_ff <= wdat[`TCC_MODE_EDGE];
            stop_on_opposite_edge_bit_ff <= wdat[`TCC_MODE_STOPOPP];
            source_clock_select_ff <= wdat[`TCC_MODE_CKS_MSB:`TCC_MODE_CKS_LSB];
         end
      end
   end

   // Compare holding latch, double buffer and active register.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmp_hold_ff <= `TCC_HOLD_RST;
         cmp_active_ff <= `TCC_CMP_RST;
         cmp_buf_ff <= `TCC_CMP_RST;
      end else if (clk_en) begin
         if (wr_en && reg_idx == `TCC_IDX_CMP_LO) begin
            cmp_hold_ff <= wdat;
         end
         if (match && double_buffer_bit_ff) begin
            cmp_active_ff <= cmp_buf_ff;
         end
         if (wr_en && reg_idx == `TCC_IDX_CMP_HI) begin
            cmp_buf_ff <= {wdat, cmp_hold_ff};
            if (!run_bit_ff || !double_buffer_bit_ff) begin
               cmp_active_ff <= {wdat, cmp_hold_ff};
            end
         end
      end
   end

   // Auto capture on a read of the capture low byte.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         capture_low_byte_ff <= `TCC_CAP_RST;
         capture_high_byte_ff <= `TCC_CAP_RST;
      end else if (clk_en && cap_lo_read) begin
         if (run_bit_ff) begin
            capture_low_byte_ff <= count_ff[7:0];
            capture_high_byte_ff <= count_ff[15:8];
         end else begin
            capture_low_byte_ff <= 8'h00;
            capture_high_byte_ff <= 8'h00;
         end
      end
   end

   // Read data selection.
   always @* begin
      case (reg_idx)
         `TCC_IDX_CTRL: rd_mux = {4'h0, overflow_irq_enable_ff, double_buffer_bit_ff,
                                  auto_capture_bit_ff, run_bit_ff};
         `TCC_IDX_MODE: rd_mux = {1'b0, source_clock_select_ff, stop_on_opposite_edge_bit_ff,
                                  edge_select_bit_ff, mode_select_field_ff};
         `TCC_IDX_CMP_LO: rd_mux = double_buffer_bit_ff ? cmp_buf_ff[7:0] :
                                   cmp_active_ff[7:0];
         `TCC_IDX_CMP_HI: rd_mux = double_buffer_bit_ff ? cmp_buf_ff[15:8] :
                                   cmp_active_ff[15:8];
         `TCC_IDX_CAP_LO: begin
            if (auto_capture_bit_ff) begin
               rd_mux = run_bit_ff ? count_ff[7:0] : 8'h00;
            end else begin
               rd_mux = capture_low_byte_ff;
            end
         end
         `TCC_IDX_CAP_HI: rd_mux = capture_high_byte_ff;
         `TCC_IDX_STATUS: rd_mux = {6'h00, pin_sync_ff, state_ff[1]};
         default: rd_mux = 8'h00;
      endcase
   end

   // Wishbone answer, one cycle after the request is seen.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (clk_en) begin
         wb_ack_o <= bus_req;
         if (rd_en) begin
            wb_dat_o <= {24'h000000, rd_mux};
         end else begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

endmodule // tcc_timer
`default_nettype wire

// ==== tcc_defines.vh ====
// Register map, field positions, reset values and prescaler masks of the timer block.
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

`define TCC_IDX_CTRL 3'h0
`define TCC_IDX_MODE 3'h1
`define TCC_IDX_CMP_LO 3'h2
`define TCC_IDX_CMP_HI 3'h3
`define TCC_IDX_CAP_LO 3'h4
`define TCC_IDX_CAP_HI 3'h5
`define TCC_IDX_STATUS 3'h6

`define TCC_CTRL_RUN 0
`define TCC_CTRL_ACAP 1
`define TCC_CTRL_DBUF 2
`define TCC_CTRL_OVFE 3

`define TCC_MODE_SEL_LSB 0
`define TCC_MODE_SEL_MSB 2
`define TCC_MODE_EDGE 3
`define TCC_MODE_STOPOPP 4
`define TCC_MODE_CKS_LSB 5
`define TCC_MODE_CKS_MSB 6

`define TCC_MODE_EXT_TRIG 3'h4
`define TCC_MODE_EVENT 3'h2

`define TCC_CMP_RST 16'hFFFF
`define TCC_CAP_RST 8'hFF
`define TCC_HOLD_RST 8'hFF
`define TCC_COUNT_RST 16'h0000

`define TCC_PRESC_W 10
`define TCC_PRESC_MASK0 10'h3FF
`define TCC_PRESC_MASK1 10'h03F
`define TCC_PRESC_MASK2 10'h003
`define TCC_PRESC_MASK3 10'h001

`endif

// ==== tcc_timer_props.sv ====
// Concurrent checks on the bus and interrupt ports of the timer block.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_props (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic timer_input_pin,
   input wire logic timer_interrupt_request
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_req_answer: assert property (s_take |=> s_pulse)
      else $error("bus request not answered as a one cycle ack");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_irq_pulse: assert property (timer_interrupt_request |=> !timer_interrupt_request)
      else $error("interrupt held longer than one cycle");
   a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data above the byte not zero");
   a_write_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
      else $error("read data not zero on a write ack");
   a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[4:2] == 3'h7
      |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
endmodule // tcc_timer_props
bind tcc_timer tcc_timer_props i_props (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .timer_input_pin(timer_input_pin), .timer_interrupt_request(timer_interrupt_request));
`default_nettype wire

// ==== tcc_pulse_src.sv ====
// Behavioural pulse source that drives the timer input pin.
`timescale 1ns/100ps
`default_nettype none
module tcc_pulse_src (
   input wire logic mclk,
   input wire logic start,
   input wire logic [7:0] half,
   input wire logic [7:0] num,
   output logic pin = 1'h0,
   output logic busy = 1'h0
);
   logic [7:0] left_ff = 8'h0;
   logic [7:0] tick_ff = 8'h0;
   always @(posedge mclk) begin
      if (start && !busy) begin
         busy <= 1'h1;
         left_ff <= num;
         tick_ff <= half;
         pin <= 1'h1;
      end else if (busy) begin
         if (tick_ff > 8'h1) begin
            tick_ff <= tick_ff - 8'h1;
         end else begin
            tick_ff <= half;
            if (pin) begin
               pin <= 1'h0;
               left_ff <= left_ff - 8'h1;
            end else if (left_ff == 8'h0) begin
               busy <= 1'h0;
            end else begin
               pin <= 1'h1;
            end
         end
      end
   end
endmodule // tcc_pulse_src
`default_nettype wire

// ==== tcc_timer_test.sv ====
// Self-checking bench for the timer block.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_test;
   logic mclk = 1'h0;
   logic reset_n = 1'h0;
   logic cyc = 1'h0, stb = 1'h0, we = 1'h0, go = 1'h0, ack, irq, pin, busy;
   logic en = 1'h1;
   logic [4:0] adr = 5'h0;
   logic [31:0] dat = 32'h0, dout;
   logic [7:0] half = 8'h3, num = 8'h1, rd;
   int error_cnt = 0, tests_run = 0, irqs = 0;
   tcc_timer i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(en), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dout), .wb_ack_o(ack), .timer_input_pin(pin), .timer_interrupt_request(irq));
   tcc_pulse_src i_src (.mclk(mclk), .start(go), .half(half), .num(num), .pin(pin),
      .busy(busy));
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) if (irq === 1'h1) irqs++;
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task xfer(input logic w, input logic [2:0] r, input logic [7:0] d);
      @(posedge mclk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {r, 2'h0};
      dat <= {24'h0, d};
      @(posedge mclk);
      while (ack !== 1'h1) @(posedge mclk);
      rd = dout[7:0];
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask
   task rdchk(input logic [2:0] r, input logic [7:0] e);
      xfer(1'h0, r, 8'h0);
      chk(rd, e);
   endtask
   task fire(input logic [7:0] n, input logic [7:0] h);
      @(posedge mclk);
      go <= 1'h1;
      num <= n;
      half <= h;
      @(posedge mclk);
      go <= 1'h0;
   endtask
   task wait_src;
      @(posedge mclk);
      while (busy === 1'h1) @(posedge mclk);
      repeat (4) @(posedge mclk);
   endtask
   task pulses(input logic [7:0] n);
      fire(n, 8'h3);
      wait_src;
   endtask
   task t_reset;
      rdchk(3'h0, 8'h00);
      rdchk(3'h1, 8'h00);
      rdchk(3'h2, 8'hFF);
      rdchk(3'h3, 8'hFF);
      rdchk(3'h5, 8'hFF);
      xfer(1'h1, 3'h7, 8'h5A);
      rdchk(3'h7, 8'h00);
   endtask
   task t_event(input logic e);
      int n0;
      xfer(1'h1, 3'h1, {4'h0, e, 3'h2});
      xfer(1'h1, 3'h2, 8'h03);
      xfer(1'h1, 3'h3, 8'h00);
      xfer(1'h1, 3'h0, 8'h03);
      n0 = irqs;
      pulses(8'h2);
      rdchk(3'h4, 8'h02);
      rdchk(3'h5, 8'h00);
      pulses(8'h1);
      chk(irqs - n0, 1);
      rdchk(3'h4, 8'h00);
      xfer(1'h1, 3'h1, 8'h00);
      rdchk(3'h1, {4'h0, e, 3'h2});
      xfer(1'h1, 3'h2, 8'h02);
      xfer(1'h1, 3'h3, 8'h00);
      pulses(8'h2);
      chk(irqs - n0, 2);
      xfer(1'h1, 3'h0, 8'h00);
      rdchk(3'h0, 8'h02);
      rdchk(3'h4, 8'h00);
      rdchk(3'h5, 8'h00);
   endtask
   task t_dbuf;
      int n0;
      xfer(1'h1, 3'h0, 8'h04);
      xfer(1'h1, 3'h2, 8'h05);
      xfer(1'h1, 3'h3, 8'h00);
      rdchk(3'h2, 8'h05);
      xfer(1'h1, 3'h1, 8'h02);
      xfer(1'h1, 3'h0, 8'h05);
      n0 = irqs;
      xfer(1'h1, 3'h2, 8'h02);
      xfer(1'h1, 3'h3, 8'h00);
      rdchk(3'h2, 8'h02);
      pulses(8'h4);
      chk(irqs - n0, 0);
      pulses(8'h1);
      chk(irqs - n0, 1);
      pulses(8'h2);
      chk(irqs - n0, 2);
      xfer(1'h1, 3'h0, 8'h00);
   endtask
   task t_trig(input logic s);
      int n0;
      xfer(1'h1, 3'h2, 8'h50);
      xfer(1'h1, 3'h3, 8'h00);
      xfer(1'h1, 3'h1, {3'h3, s, 4'h4});
      xfer(1'h1, 3'h0, 8'h03);
      n0 = irqs;
      fire(8'h1, 8'h3C);
      repeat (30) @(posedge mclk);
      xfer(1'h0, 3'h4, 8'h00);
      chk(rd != 8'h00, 1);
      rdchk(3'h6, 8'h03);
      wait_src;
      xfer(1'h0, 3'h4, 8'h00);
      chk(rd != 8'h00, !s);
      repeat (80) @(posedge mclk);
      chk(irqs - n0, !s);
      xfer(1'h1, 3'h0, 8'h00);
      rdchk(3'h4, 8'h00);
   endtask
   task t_freeze;
      xfer(1'h1, 3'h1, 8'h02);
      xfer(1'h1, 3'h2, 8'h10);
      xfer(1'h1, 3'h3, 8'h00);
      xfer(1'h1, 3'h0, 8'h03);
      en <= 1'h0;
      pulses(8'h2);
      en <= 1'h1;
      rdchk(3'h4, 8'h00);
      pulses(8'h1);
      rdchk(3'h4, 8'h01);
      xfer(1'h1, 3'h0, 8'h00);
   endtask
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'h1;
      t_reset;
      t_event(1'h0);
      t_event(1'h1);
      t_dbuf;
      t_trig(1'h1);
      t_trig(1'h0);
      t_freeze;
      tally_and_finish;
   end
   initial begin
      #100000;
      error_cnt++;
      tally_and_finish;
   end
endmodule // tcc_timer_test
`default_nettype wire
